// *** rtl/drive_terminal_function_router.v ***
// Drive terminal function router: eight programmable input terminals,
// three open-collector outputs and the alarm relay, set up over APB.
// Assumes one 10 MHz clock, synchronous active-low reset, raw pin levels.
//
// Function
// - An input counts as asserted while shorted to return, deasserted while open.
// - Eight input channels, each with a function code from 0 to 99.
// - Parameter reset gives input channels one to eight codes one to eight.
// - Combined codes assert several commands at once, e.g. 11 and 16.
// - Code 11 on channel one alone starts an inching forward run.
// - Codes 3, 4 drive speed select bits; code 37 selects speeds five-eight.
// - Codes 8, 9 pick ramp sets two, three, or four when both.
// - Code 6 gives emergency stop, also usable as down-adjust.
// - Code 7 gives alarm reset, also usable as up-adjust.
// - Code 35 clears the scheduled operation timer.
// - Code 36 gives the current-loop input frequency priority.
// - Codes 39 to 42 drive the pump option signals.
// - Codes 43, 44, 45 drive the positioning option signals.
// - Code 46 toggles closed-loop control; codes 47 to 53 pick external motors.
// - Each open-collector output turns on per its own function code.
// - Relay make open, break closed normally; reversed after a protective stop.
// - The relay can instead act as a multifunction contact output.
// - Current-loop priority makes the 4-20 mA input the first speed source.
// - Output codes 18 to 27 mirror the matching input commands.
//
// Chosen here: the register offsets and the APB interface to the registers.
`include "drive_terminal_function_router_map.vh"

module drive_terminal_function_router (
   input wire i_clk_sys,
   input wire i_nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [7:0] i_input_pin_n,
   input wire [31:0] i_drive_status,
   input wire i_protective_trip,
   output reg [`CMD_W-1:0] o_commands,
   output reg [2:0] o_speed_index,
   output reg [1:0] o_ramp_set,
   output reg o_freq_src_current_loop,
   output reg [`NUM_OUTPUTS-1:0] o_output_pin,
   output reg o_relay_make_contact,
   output reg o_relay_break_contact
);

   // Function code storage, addressed by channel index.
   reg [`CODE_W-1:0] input_func [0:`NUM_INPUTS-1];
   reg [`CODE_W-1:0] output_func [0:`NUM_OUTPUTS-1];
   reg [`CODE_W-1:0] relay_func;
   reg [7:0] pin_meta;
   reg [7:0] pin_sync;
   reg [`CMD_W-1:0] next_commands;
   reg [`NUM_OUTPUTS-1:0] next_output_pin;
   reg next_relay_make;
   reg [31:0] next_prdata;
   reg next_pslverr;
   wire param_reset;
   wire [`CMD_W-1:0] channel_cmd [0:`NUM_INPUTS-1];
   wire [7:0] pin_asserted;
   wire apb_access;
   wire apb_write;
   integer k;
   integer j;

   // Translates one function code into the commands it asserts.
   function [`CMD_W-1:0] decode_input;
      input [`CODE_W-1:0] code;
      reg [`CMD_W-1:0] c;
      begin
         // Code zero and every reserved code leave the vector clear.
         c = {`CMD_W{1'b0}};
         case (code)
            7'd1: c[`CMD_FORWARD_RUN] = 1'b1;
            7'd2: c[`CMD_REVERSE_RUN] = 1'b1;
            7'd3: c[`CMD_SPEED_SELECT_A] = 1'b1;
            7'd4: c[`CMD_SPEED_SELECT_B] = 1'b1;
            7'd5: c[`CMD_COAST_STOP] = 1'b1;
            7'd6: c[`CMD_EMERGENCY_STOP] = 1'b1;
            7'd7: c[`CMD_FAULT_CLEAR] = 1'b1;
            7'd8: c[`CMD_RAMP_SELECT_A] = 1'b1;
            7'd9: c[`CMD_RAMP_SELECT_B] = 1'b1;
            7'd10: c[`CMD_INCHING] = 1'b1;
            7'd11: c = fr_rr(1'b1) | bit1(`CMD_INCHING);
            7'd12: c = fr_rr(1'b0) | bit1(`CMD_INCHING);
            7'd13: c = fr_rr(1'b1) | bit1(`CMD_RAMP_SELECT_A);
            7'd14: c = fr_rr(1'b0) | bit1(`CMD_RAMP_SELECT_A);
            7'd15: c = fr_rr(1'b1) | bit1(`CMD_RAMP_SELECT_B);
            7'd16: c = fr_rr(1'b0) | bit1(`CMD_RAMP_SELECT_B);
            7'd35: c[`CMD_SCHEDULE_TIMER_CLEAR] = 1'b1;
            7'd36: c[`CMD_CURRENT_LOOP_INPUT] = 1'b1;
            7'd37: c[`CMD_SPEED_SELECT_C] = 1'b1;
            7'd38: c[`CMD_RUN_LATCH] = 1'b1;
            7'd39: c[`CMD_SECOND_PRESSURE] = 1'b1;
            7'd40: c[`CMD_SECOND_PUMP_TIME_SELECT] = 1'b1;
            7'd41: c[`CMD_DUTY_PUMP_TIMER_CLEAR] = 1'b1;
            7'd42: c = bit1(`CMD_SECOND_PRESSURE) | bit1(`CMD_SECOND_PUMP_TIME_SELECT);
            7'd43: c[`CMD_PULSE_BLOCK] = 1'b1;
            7'd44: c[`CMD_POSITION_ERROR_CLEAR] = 1'b1;
            7'd45: c[`CMD_PROPORTIONAL_ONLY] = 1'b1;
            7'd46: c[`CMD_LOOP_CONTROL_SELECT] = 1'b1;
            7'd55: c[`CMD_ZERO_SPEED] = 1'b1;
            7'd56: c = fr_rr(1'b1) | bit1(`CMD_POSITION_ERROR_CLEAR);
            7'd57: c = fr_rr(1'b0) | bit1(`CMD_POSITION_ERROR_CLEAR);
            7'd62: c = fr_rr(1'b1) | bit1(`CMD_COAST_STOP);
            7'd63: c = fr_rr(1'b1) | bit1(`CMD_COAST_STOP);
            7'd65: c = bit1(`CMD_SPEED_SELECT_A) | bit1(`CMD_RAMP_SELECT_A);
            7'd66: c = bit1(`CMD_SPEED_SELECT_A) | bit1(`CMD_RAMP_SELECT_B);
            7'd67: c = bit1(`CMD_SPEED_SELECT_B) | bit1(`CMD_RAMP_SELECT_A);
            7'd68: c = bit1(`CMD_SPEED_SELECT_B) | bit1(`CMD_RAMP_SELECT_B);
            7'd69: c[`CMD_GEAR_X10] = 1'b1;
            7'd70: c[`CMD_GEAR_X100] = 1'b1;
            default:
            begin
               // Codes 17 to 34 pair a run direction with speed and ramp selects.
               if (code >= 7'd17 && code <= 7'd34)
               begin
                  c = fr_rr(code[0]) | combo_selects(code);
               end
               // Codes 47 to 53 pick one external motor each.
               else if (code >= 7'd47 && code <= 7'd53)
               begin
                  c = bit1(`CMD_EXTERNAL_MOTOR_BASE + code - 7'd47);
               end
            end
         endcase
         decode_input = c;
      end
   endfunction

   // One-hot vector with a single command bit set.
   function [`CMD_W-1:0] bit1;
      input integer pos;
      begin
         bit1 = {{(`CMD_W-1){1'b0}}, 1'b1} << pos;
      end
   endfunction

   // Forward run when fwd is high, reverse run otherwise.
   function [`CMD_W-1:0] fr_rr;
      input fwd;
      begin
         fr_rr = fwd ? bit1(`CMD_FORWARD_RUN) : bit1(`CMD_REVERSE_RUN);
      end
   endfunction

   // Speed and ramp selects of combined codes 17 to 34, two codes per step.
   function [`CMD_W-1:0] combo_selects;
      input [`CODE_W-1:0] code;
      reg [`CODE_W-1:0] step;
      reg [1:0] spd;
      begin
         step = (code - 7'd17) >> 1;
         spd = (step % 7'd3 == 7'd0) ? 2'b01 : ((step % 7'd3 == 7'd1) ? 2'b10 : 2'b11);
         combo_selects = (spd[0] ? bit1(`CMD_SPEED_SELECT_A) : {`CMD_W{1'b0}})
            | (spd[1] ? bit1(`CMD_SPEED_SELECT_B) : {`CMD_W{1'b0}})
            | ((step >= 7'd3 && step <= 7'd5) ? bit1(`CMD_RAMP_SELECT_A) : {`CMD_W{1'b0}})
            | ((step >= 7'd6) ? bit1(`CMD_RAMP_SELECT_B) : {`CMD_W{1'b0}});
      end
   endfunction

   // State of one output for a given function code.
   function output_level;
      input [`CODE_W-1:0] code;
      input [`CMD_W-1:0] cmd;
      input [31:0] status;
      begin
         // Code zero, reserved and unused codes keep the output off.
         output_level = 1'b0;
         case (code)
            7'd18: output_level = cmd[`CMD_FORWARD_RUN];
            7'd19: output_level = cmd[`CMD_REVERSE_RUN];
            7'd20: output_level = cmd[`CMD_SPEED_SELECT_A];
            7'd21: output_level = cmd[`CMD_SPEED_SELECT_B];
            7'd22: output_level = cmd[`CMD_RAMP_SELECT_A];
            7'd23: output_level = cmd[`CMD_RAMP_SELECT_B];
            7'd24: output_level = cmd[`CMD_INCHING];
            7'd25: output_level = cmd[`CMD_COAST_STOP];
            7'd26: output_level = cmd[`CMD_EMERGENCY_STOP];
            7'd27: output_level = cmd[`CMD_FAULT_CLEAR];
            default:
            begin
               // Codes 1 to 17, 28 and 29 follow drive status; others are unused.
               if ((code >= 7'd1 && code <= 7'd17) || code == 7'd28 || code == 7'd29)
               begin
                  output_level = status[code[4:0]];
               end
            end
         endcase
      end
   endfunction

   // Two-stage synchroniser for the raw terminal levels.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         pin_meta <= 8'hFF;
         pin_sync <= 8'hFF;
      end
      else
      begin
         pin_meta <= i_input_pin_n;
         pin_sync <= pin_meta;
      end
   end

   // A terminal pulled low to the return is asserted.
   assign pin_asserted = ~pin_sync;

   // Per-channel decode gated by the channel's own terminal.
   genvar g;
   generate
      for (g = 0; g < `NUM_INPUTS; g = g + 1)
      begin : chan
         assign channel_cmd[g] = pin_asserted[g] ? decode_input(input_func[g])
            : {`CMD_W{1'b0}};
      end
   endgenerate

   // Merges all channels and selects output and relay levels.
   always @*
   begin
      next_commands = {`CMD_W{1'b0}};
      for (k = 0; k < `NUM_INPUTS; k = k + 1)
      begin
         next_commands = next_commands | channel_cmd[k];
      end
      for (k = 0; k < `NUM_OUTPUTS; k = k + 1)
      begin
         next_output_pin[k] = output_level(output_func[k], next_commands, i_drive_status);
      end
      // Relay code zero is the alarm relay; any other code is a multifunction contact.
      next_relay_make = (relay_func == `RELAY_FUNC_RESET) ? i_protective_trip
         : output_level(relay_func, next_commands, i_drive_status);
   end

   // Registered router outputs.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         o_commands <= {`CMD_W{1'b0}};
         o_speed_index <= 3'h0;
         o_ramp_set <= 2'h0;
         o_freq_src_current_loop <= 1'b0;
         o_output_pin <= 3'h0;
         o_relay_make_contact <= 1'b0;
         o_relay_break_contact <= 1'b1;
      end
      else
      begin
         o_commands <= next_commands;
         o_speed_index <= {next_commands[`CMD_SPEED_SELECT_C],
            next_commands[`CMD_SPEED_SELECT_B], next_commands[`CMD_SPEED_SELECT_A]};
         o_ramp_set <= {next_commands[`CMD_RAMP_SELECT_B],
            next_commands[`CMD_RAMP_SELECT_A]};
         o_freq_src_current_loop <= next_commands[`CMD_CURRENT_LOOP_INPUT];
         o_output_pin <= next_output_pin;
         o_relay_make_contact <= next_relay_make;
         o_relay_break_contact <= ~next_relay_make;
      end
   end

   assign apb_access = psel && penable && !pready;
   assign apb_write = psel && penable && pready && pwrite && !pslverr;

   // Read data and error answer for the current address.
   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (paddr[1:0] != 2'h0)
      begin
         next_pslverr = 1'b1;
      end
      else if (paddr < `ADDR_OUTPUT_FUNC_BASE)
      begin
         next_prdata = {25'h0000000, input_func[paddr[4:2]]};
      end
      else if (paddr < `ADDR_RELAY_FUNC)
      begin
         next_prdata = {25'h0000000, output_func[paddr[3:2]]};
      end
      else if (paddr == `ADDR_RELAY_FUNC)
      begin
         next_prdata = {25'h0000000, relay_func};
      end
      else if (paddr == `ADDR_PIN_STATUS)
      begin
         next_prdata = {24'h000000, pin_asserted};
      end
      else if (paddr == `ADDR_COMMAND_STATUS)
      begin
         next_prdata = {1'b0, o_commands};
      end
      // The parameter reset register is write-only and reads as zero.
      else if (paddr != `ADDR_PARAM_RESET)
      begin
         next_pslverr = 1'b1;
      end
   end

   // APB slave: one wait state, write takes effect as pready is sampled.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (apb_access)
      begin
         pready <= 1'b1;
         pslverr <= next_pslverr;
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // A write of one to the parameter reset register restores every code.
   assign param_reset = apb_write && paddr == `ADDR_PARAM_RESET && pwdata[0];

   // Function code registers with parameter reset to the defaults.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst || param_reset)
      begin
         for (j = 0; j < `NUM_INPUTS; j = j + 1)
         begin
            input_func[j] <= j[`CODE_W-1:0] + 7'h01;
         end
         output_func[0] <= `OUT1_FUNC_RESET;
         output_func[1] <= `OUT2_FUNC_RESET;
         output_func[2] <= `OUT3_FUNC_RESET;
         relay_func <= `RELAY_FUNC_RESET;
      end
      else if (apb_write && pwdata[6:0] <= `CODE_MAX)
      begin
         if (paddr < `ADDR_OUTPUT_FUNC_BASE)
         begin
            input_func[paddr[4:2]] <= pwdata[6:0];
         end
         else if (paddr < `ADDR_RELAY_FUNC)
         begin
            output_func[paddr[3:2]] <= pwdata[6:0];
         end
         else if (paddr == `ADDR_RELAY_FUNC)
         begin
            relay_func <= pwdata[6:0];
         end
      end
   end

endmodule

// *** rtl/drive_terminal_function_router_map.vh ***
// Constants of the drive terminal function router: register offsets,
// reset values and the bit positions of the internal command vector.
// Assumes a 32-bit APB register bus with byte addresses.
`ifndef DRIVE_TERMINAL_FUNCTION_ROUTER_MAP_VH
`define DRIVE_TERMINAL_FUNCTION_ROUTER_MAP_VH

// Register byte offsets.
`define ADDR_INPUT_FUNC_BASE 8'h00
`define ADDR_OUTPUT_FUNC_BASE 8'h20
`define ADDR_RELAY_FUNC 8'h2C
`define ADDR_PIN_STATUS 8'h30
`define ADDR_COMMAND_STATUS 8'h34
`define ADDR_PARAM_RESET 8'h38

// Widths and counts.
`define CODE_W 7
`define CMD_W 31
`define NUM_INPUTS 8
`define NUM_OUTPUTS 3

// Reset values of the output and relay function codes.
`define OUT1_FUNC_RESET 7'h01
`define OUT2_FUNC_RESET 7'h05
`define OUT3_FUNC_RESET 7'h08
`define RELAY_FUNC_RESET 7'h00

// Highest code that is not reserved.
`define CODE_MAX 7'h63

// Bit positions in the internal command vector.
`define CMD_FORWARD_RUN 0
`define CMD_REVERSE_RUN 1
`define CMD_SPEED_SELECT_A 2
`define CMD_SPEED_SELECT_B 3
`define CMD_COAST_STOP 4
`define CMD_EMERGENCY_STOP 5
`define CMD_FAULT_CLEAR 6
`define CMD_RAMP_SELECT_A 7
`define CMD_RAMP_SELECT_B 8
`define CMD_INCHING 9
`define CMD_SCHEDULE_TIMER_CLEAR 10
`define CMD_CURRENT_LOOP_INPUT 11
`define CMD_SPEED_SELECT_C 12
`define CMD_RUN_LATCH 13
`define CMD_SECOND_PRESSURE 14
`define CMD_SECOND_PUMP_TIME_SELECT 15
`define CMD_DUTY_PUMP_TIMER_CLEAR 16
`define CMD_PULSE_BLOCK 17
`define CMD_POSITION_ERROR_CLEAR 18
`define CMD_PROPORTIONAL_ONLY 19
`define CMD_LOOP_CONTROL_SELECT 20
`define CMD_EXTERNAL_MOTOR_BASE 21
`define CMD_ZERO_SPEED 28
`define CMD_GEAR_X10 29
`define CMD_GEAR_X100 30

`endif

// *** tb/drive_terminal_function_router_assertions.sv ***
// Checker for the drive terminal function router: APB answer timing,
// relay contacts and the decoded selector outputs.
// Assumes it is bound to the router's top module and sees only its ports.
`include "drive_terminal_function_router_map.vh"
module drive_terminal_function_router_checker (
   input wire i_clk_sys,
   input wire i_nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire i_protective_trip,
   input wire [`CMD_W-1:0] o_commands,
   input wire [2:0] o_speed_index,
   input wire [1:0] o_ramp_set,
   input wire o_freq_src_current_loop,
   input wire o_relay_make_contact,
   input wire o_relay_break_contact
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] relay_code;
   wire done = psel && penable && pready && pwrite;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // Follows the relay function code as software writes or restores it.
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
         relay_code <= 7'h00;
      else if (done && paddr == `ADDR_RELAY_FUNC && pwdata[6:0] <= `CODE_MAX)
         relay_code <= pwdata[6:0];
      else if (done && paddr == `ADDR_PARAM_RESET && pwdata[0])
         relay_code <= 7'h00;
   end
   sequence access_start;
      psel && penable && !pready;
   endsequence
   sequence answer;
      pready ##1 !pready;
   endsequence
   ready_latency_a: assert property (access_start |=> answer)
      else $error("pready late after access phase");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access phase");
   err_unaligned_a: assert property (access_start ##0 (paddr[1:0] != 2'b00) |=> pslverr)
      else $error("unaligned access not refused");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr outside answer cycle");
   relay_inverse_a: assert property (o_relay_break_contact != o_relay_make_contact)
      else $error("relay contacts not complementary");
   relay_alarm_a: assert property ((relay_code == 7'h00) |=>
      o_relay_make_contact == $past(i_protective_trip))
      else $error("alarm relay does not follow trip");
   speed_index_a: assert property (o_speed_index == {o_commands[12], o_commands[3:2]})
      else $error("speed index differs from selects");
   ramp_set_a: assert property (o_ramp_set == o_commands[8:7])
      else $error("ramp set differs from selects");
   freq_source_a: assert property (o_freq_src_current_loop == o_commands[11])
      else $error("frequency source differs from priority");
endmodule
bind drive_terminal_function_router drive_terminal_function_router_checker checker_inst (
   .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .i_protective_trip(i_protective_trip), .o_commands(o_commands),
   .o_speed_index(o_speed_index), .o_ramp_set(o_ramp_set),
   .o_freq_src_current_loop(o_freq_src_current_loop),
   .o_relay_make_contact(o_relay_make_contact), .o_relay_break_contact(o_relay_break_contact));

// *** tb/terminal_switches.sv ***
// Model of the external switches that short input terminals to return.
// Assumes the device pulls each terminal up, so an open switch reads high.
module terminal_switches (
   input wire logic [7:0] i_closed,
   output logic [7:0] o_pin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // A closed switch pulls its terminal low; an open one floats to the pull-up.
   assign o_pin_n = ~i_closed;
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the drive terminal function router over APB.
// Assumes the map header on the include path and the checker bound.
`include "drive_terminal_function_router_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys = 1'b0;
   logic i_nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, i_drive_status = 32'h0, rdat;
   logic i_protective_trip = 1'b0, rerr;
   logic [7:0] closed = 8'h00;
   wire [7:0] pin_n;
   wire [31:0] prdata;
   wire pready, pslverr, o_freq_src_current_loop, o_relay_make_contact, o_relay_break_contact;
   wire [`CMD_W-1:0] o_commands;
   wire [2:0] o_speed_index, o_output_pin;
   wire [1:0] o_ramp_set;
   int mismatches = 0, n_checks = 0, cycles = 0;
   logic [6:0] codes [25] = '{7'h0B, 7'h10, 7'h23, 7'h24, 7'h25, 7'h27, 7'h28, 7'h29,
      7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h3E, 7'h41, 7'h15, 7'h1E, 7'h21,
      7'h26, 7'h35, 7'h38, 7'h00, 7'h36, 7'h63};
   logic [31:0] masks [25] = '{32'h201, 32'h102, 32'h400, 32'h800, 32'h1000, 32'h4000,
      32'h8000, 32'h10000, 32'hC000, 32'h20000, 32'h40000, 32'h80000, 32'h100000,
      32'h200000, 32'h11, 32'h84, 32'hD, 32'h106, 32'h10D, 32'h2000, 32'h8000000,
      32'h40001, 32'h0, 32'h0, 32'h0};
   drive_terminal_function_router drive_terminal_function_router_inst (
      .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_input_pin_n(pin_n), .i_drive_status(i_drive_status),
      .i_protective_trip(i_protective_trip), .o_commands(o_commands),
      .o_speed_index(o_speed_index), .o_ramp_set(o_ramp_set),
      .o_freq_src_current_loop(o_freq_src_current_loop), .o_output_pin(o_output_pin),
      .o_relay_make_contact(o_relay_make_contact),
      .o_relay_break_contact(o_relay_break_contact));
   terminal_switches terminal_switches_inst (.i_closed(closed), .o_pin_n(pin_n));
   // Free-running system clock of 100 ns period.
   always #50 i_clk_sys = ~i_clk_sys;
   // Cuts a hung run short.
   always @(posedge i_clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One APB transfer; the answer is kept in rdat and rerr.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      @(posedge i_clk_sys);
      while (pready !== 1'b1)
         @(posedge i_clk_sys);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), exp, rdat);
   endtask
   // Sets the switches and waits past the synchroniser and output stage.
   task automatic pins(input logic [7:0] m);
      closed <= m;
      repeat (4) @(posedge i_clk_sys);
   endtask
   // Main sequence.
   initial
   begin
      repeat (2) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      for (int i = 0; i < 8; i++)
         rd(8'(i * 4), 32'(i + 1));
      rd(8'h20, 32'h1);
      rd(8'h2C, 32'h0);
      chk("break", 32'h1, {31'h0, o_relay_break_contact});
      pins(8'hFF);
      chk("commands", 32'hFF, {1'b0, o_commands});
      rd(8'h30, 32'hFF);
      pins(8'h00);
      chk("commands", 32'h0, {1'b0, o_commands});
      apb(1'b1, 8'h04, 32'h9);
      apb(1'b1, 8'h10, 32'h25);
      pins(8'h9E);
      chk("commands", 32'h118C, {1'b0, o_commands});
      chk("speed", 32'h7, {29'h0, o_speed_index});
      chk("ramp", 32'h3, {30'h0, o_ramp_set});
      rd(8'h34, 32'h118C);
      apb(1'b1, 8'h38, 32'h1);
      rd(8'h04, 32'h2);
      pins(8'h01);
      for (int i = 0; i < 25; i++)
      begin
         apb(1'b1, 8'h00, {25'h0, codes[i]});
         repeat (2) @(posedge i_clk_sys);
         chk("commands", masks[i], {1'b0, o_commands});
         if (codes[i] == 7'h24)
            chk("freq_src", 32'h1, {31'h0, o_freq_src_current_loop});
      end
      rd(8'h00, 32'h63);
      apb(1'b1, 8'h00, 32'h64);
      rd(8'h00, 32'h63);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      pins(8'h03);
      chk("commands", 32'h1, {1'b0, o_commands});
      pins(8'h02);
      chk("commands", 32'h1, {1'b0, o_commands});
      apb(1'b1, 8'h20, 32'h12);
      apb(1'b1, 8'h24, 32'h3);
      apb(1'b1, 8'h28, 32'h0);
      i_drive_status <= 32'h8;
      pins(8'h02);
      chk("outputs", 32'h3, {29'h0, o_output_pin});
      i_protective_trip <= 1'b1;
      pins(8'h00);
      chk("outputs", 32'h2, {29'h0, o_output_pin});
      chk("make", 32'h1, {31'h0, o_relay_make_contact});
      chk("break", 32'h0, {31'h0, o_relay_break_contact});
      apb(1'b1, 8'h2C, 32'h12);
      repeat (2) @(posedge i_clk_sys);
      chk("make", 32'h0, {31'h0, o_relay_make_contact});
      pins(8'h01);
      chk("make", 32'h1, {31'h0, o_relay_make_contact});
      i_protective_trip <= 1'b0;
      apb(1'b0, 8'h3C, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      apb(1'b0, 8'h02, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      end_of_test();
   end
endmodule
